//--- src/dds_output_select_startup.sv
// Purpose: Output routing, waveform choice, reset and start-up latency of a DDS core.
// Assumes: Single 25 MHz clock; APB slave; host obeys reset and reserved settings.
// Notes:   Square pin is a tri-state pair; the analog output is a 10-bit DAC code.
//
// What this block does
// - Comparator drives square pin when selected.
// - DAC data top bit drives square pin.
// - Halve bit set passes top bit undivided; clear divides it by two.
// - Mode and enable bits choose sine or triangle.
// - Sine mode passes phase through lookup table.
// - Triangle mode bypasses table, 10-bit ramp.
// - Reset clears accumulator path to midscale.
// - Reset leaves phase, frequency, control untouched.
// - Output appears eight or nine cycles later.
// - Frequency select pin picks frequency register.
// - Two phase registers shift carrier phase.
// - Select bit picks reset pin or bit.
// - Pin assert immediate, release sampled later.
// - Square pin high impedance when disabled.
//
// Our own choices: the APB register port and the register offsets.
`include "dds_consts.svh"

module dds_output_select_startup
  import dds_pkg::*;
(
  input  wire logic              clk_i,          // Master clock, 25 MHz
  input  wire logic              reset_i,        // Async reset, active high
  input  wire logic              psel_i,         // APB select
  input  wire logic              penable_i,      // APB enable
  input  wire logic              pwrite_i,       // APB write
  input  wire logic [11:0]       paddr_i,        // APB byte address
  input  wire logic [31:0]       pwdata_i,       // APB write data
  output logic      [31:0]       prdata_o,       // APB read data
  output logic                   pready_o,       // APB ready
  output logic                   pslverr_o,      // APB error, unmapped address
  input  wire logic              reset_pin_i,    // Device reset pin
  input  wire logic              freq_register_select_pin_i, // FSK select pin
  input  wire logic              phase_select_pin_i,         // PSK select pin
  input  wire logic              comparator_i,   // On-board comparator result
  output logic [`DAC_W-1:0]      dac_code_o,     // DAC code, midscale in reset
  output logic                   dac_powered_o,  // DAC enabled
  output logic                   square_o,       // Square pin output value
  output logic                   square_oe_o     // Square pin output enable
);

  // ==========================================================
  // Register storage
  ctrl_s                ctrl_q;
  logic [`FREQ_W-1:0]   freq0_q, freq1_q;
  logic [`PHASE_W-1:0]  phase0_q, phase1_q;
  logic                 wr_en, rd_en, addr_ok;

  assign wr_en   = psel_i & penable_i & pwrite_i;
  assign rd_en   = psel_i & penable_i & ~pwrite_i;
  assign addr_ok = (paddr_i == `OFS_CONTROL) | (paddr_i == `OFS_FREQ0) | (paddr_i == `OFS_FREQ1) |
                   (paddr_i == `OFS_PHASE0) | (paddr_i == `OFS_PHASE1) | (paddr_i == `OFS_STATUS);

  always_ff @(posedge clk_i) begin
    if (wr_en) begin
      case (paddr_i)
        `OFS_CONTROL: begin
          ctrl_q.square_pin_enable       <= pwdata_i[`BIT_SQEN];
          ctrl_q.comparator_route_select <= pwdata_i[`BIT_CMPSEL];
          ctrl_q.halve_square_frequency  <= pwdata_i[`BIT_HALVE];
          ctrl_q.mode_triangle           <= pwdata_i[`BIT_MODE];
          ctrl_q.dac_powerdown_bit       <= pwdata_i[`BIT_DACPD];
          ctrl_q.pin_or_software_select  <= pwdata_i[`BIT_PINSW];
          ctrl_q.reset_bit               <= pwdata_i[`BIT_RESET];
          ctrl_q.freq_sel_bit            <= pwdata_i[`BIT_FSEL];
          ctrl_q.phase_sel_bit           <= pwdata_i[`BIT_PSEL];
        end
        `OFS_FREQ0:  freq0_q  <= pwdata_i[`FREQ_W-1:0];
        `OFS_FREQ1:  freq1_q  <= pwdata_i[`FREQ_W-1:0];
        `OFS_PHASE0: phase0_q <= pwdata_i[`PHASE_W-1:0];
        `OFS_PHASE1: phase1_q <= pwdata_i[`PHASE_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Pin synchronisers
  logic [1:0] fsel_sync_q, psel_sync_q, cmp_sync_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fsel_sync_q <= 2'h0;
      psel_sync_q <= 2'h0;
      cmp_sync_q  <= 2'h0;
    end else begin
      fsel_sync_q <= {fsel_sync_q[0], freq_register_select_pin_i};
      psel_sync_q <= {psel_sync_q[0], phase_select_pin_i};
      cmp_sync_q  <= {cmp_sync_q[0], comparator_i};
    end
  end

  // ==========================================================
  // Internal reset
  // immediate assert
  // Pin assertion sets both stages at once; release walks through two
  // falling-edge stages so a pin edge near the clock cannot split the reset.
  logic [1:0] pin_rst_q;
  logic       core_rst;

  always_ff @(negedge clk_i or posedge reset_pin_i) begin
    if (reset_pin_i) begin
      pin_rst_q <= 2'h3;
    end else begin
      pin_rst_q <= {pin_rst_q[0], 1'b0};
    end
  end

  logic sel_pin_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_pin_q <= 1'b1;
    end else begin
      sel_pin_q <= ctrl_q.pin_or_software_select;
    end
  end

  // The selected source acts at once; core_rst_q only reports the state
  assign core_rst = reset_i | (sel_pin_q ? pin_rst_q[1] : ctrl_q.reset_bit);

  logic core_rst_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      core_rst_q <= 1'b1;
    end else begin
      core_rst_q <= core_rst;
    end
  end

  // ==========================================================
  // Accumulator and phase
  logic [`FREQ_W-1:0]  acc_q;
  logic [`FREQ_W-1:0]  step;
  logic [`PHASE_W-1:0] poff;
  logic                fsel, psel;

  assign fsel = sel_pin_q ? fsel_sync_q[1] : ctrl_q.freq_sel_bit;
  assign step = fsel ? freq1_q : freq0_q;
  assign psel = sel_pin_q ? psel_sync_q[1] : ctrl_q.phase_sel_bit;
  assign poff = psel ? phase1_q : phase0_q;

  always_ff @(posedge clk_i or posedge core_rst) begin
    if (core_rst) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_q + step;
    end
  end

  logic [`PHASE_W-1:0] phase_w;
  assign phase_w = acc_q[`FREQ_W-1 -: `PHASE_W] + poff;

  // ==========================================================
  // Sine table, quarter wave, computed combinationally
  logic [`DAC_W-1:0] sine_code;
  logic [`DAC_W-1:0] tri_code;

  function automatic logic [8:0] quarter_sine(input logic [9:0] idx);
    logic [8:0]  x;
    logic [17:0] bend;
    x    = idx[9] ? ~idx[8:0] : idx[8:0];
    bend = (18'(x) * 18'(9'h1ff - x)) >> 9;
    // Parabolic quarter sine; peaks at 511 exactly, so the top never wraps to zero
    quarter_sine = 9'(18'(x) + bend);
  endfunction : quarter_sine

  always_comb begin
    logic [8:0] mag;
    mag = quarter_sine(phase_w[10:1]);
    sine_code = phase_w[11] ? 10'(10'h1ff - {1'b0, mag}) : 10'(10'h200 + {1'b0, mag});
  end

  assign tri_code = phase_w[11] ? ~phase_w[10:1] : phase_w[10:1];

  logic use_tri;
  assign use_tri = ctrl_q.mode_triangle & ~ctrl_q.square_pin_enable;

  // ==========================================================
  // Latency pipeline, midscale while in reset
  // nine cycle start
  // Pin release gives nine clocks to the first code, bit release eight.
  logic [`DAC_W-1:0] pipe_q [`LAT_STAGES];

  always_ff @(posedge clk_i or posedge core_rst) begin
    if (core_rst) begin
      for (int i = 0; i < `LAT_STAGES; i++) begin
        pipe_q[i] <= 10'h200;
      end
    end else begin
      pipe_q[0] <= use_tri ? tri_code : sine_code;
      for (int i = 1; i < `LAT_STAGES; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  always_ff @(posedge clk_i or posedge core_rst) begin
    if (core_rst) begin
      dac_code_o <= 10'h200;
    end else begin
      dac_code_o <= pipe_q[`LAT_STAGES-1];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dac_powered_o <= 1'b0;
    end else begin
      dac_powered_o <= ~ctrl_q.dac_powerdown_bit;
    end
  end

  // ==========================================================
  // Square output
  logic msb_half_q;
  logic msb_prev_q;

  always_ff @(posedge clk_i or posedge core_rst) begin
    if (core_rst) begin
      msb_half_q <= 1'b0;
      msb_prev_q <= 1'b0;
    end else begin
      msb_prev_q <= pipe_q[`LAT_STAGES-1][`DAC_W-1];
      if (pipe_q[`LAT_STAGES-1][`DAC_W-1] & ~msb_prev_q) begin
        msb_half_q <= ~msb_half_q;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      square_o    <= 1'b0;
      square_oe_o <= 1'b0;
    end else begin
      square_oe_o <= ctrl_q.square_pin_enable;
      if (ctrl_q.comparator_route_select) begin
        square_o <= cmp_sync_q[1];
      end else if (ctrl_q.halve_square_frequency) begin
        square_o <= pipe_q[`LAT_STAGES-1][`DAC_W-1];
      end else begin
        square_o <= msb_half_q;
      end
    end
  end

  // ==========================================================
  // APB read path, zero wait states
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_o  <= 32'h0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~addr_ok;
      prdata_o  <= 32'h0;
      if (psel_i & ~penable_i & ~pwrite_i) begin
        case (paddr_i)
          `OFS_CONTROL: prdata_o <= 32'({ctrl_q.freq_sel_bit, ctrl_q.phase_sel_bit,
                                         ctrl_q.pin_or_software_select, ctrl_q.reset_bit, 1'b0,
                                         ctrl_q.dac_powerdown_bit, ctrl_q.square_pin_enable,
                                         ctrl_q.comparator_route_select, ctrl_q.halve_square_frequency,
                                         1'b0, ctrl_q.mode_triangle, 1'b0});
          `OFS_FREQ0:   prdata_o <= 32'(freq0_q);
          `OFS_FREQ1:   prdata_o <= 32'(freq1_q);
          `OFS_PHASE0:  prdata_o <= 32'(phase0_q);
          `OFS_PHASE1:  prdata_o <= 32'(phase1_q);
          `OFS_STATUS:  prdata_o <= 32'({fsel, psel, core_rst_q});
          default:      prdata_o <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  // host keeps DAC enabled; visible on dac_powered_o only.
  sequence s_release;
    $fell(core_rst_q) ##0 !core_rst;
  endsequence

  chk_square_off_disabled: assert property (@(posedge clk_i) disable iff (reset_i)
    !ctrl_q.square_pin_enable |=> !square_oe_o)
    else $error("square pin driven while disabled");

  chk_comparator_route: assert property (@(posedge clk_i) disable iff (reset_i)
    ctrl_q.square_pin_enable && ctrl_q.comparator_route_select |=> square_o == $past(cmp_sync_q[1]))
    else $error("comparator not routed");

  chk_msb_route: assert property (@(posedge clk_i) disable iff (reset_i)
    ctrl_q.square_pin_enable && !ctrl_q.comparator_route_select && ctrl_q.halve_square_frequency
    |=> square_o == $past(pipe_q[`LAT_STAGES-1][`DAC_W-1]))
    else $error("dac top bit not routed");

  chk_halve_toggle: assert property (@(posedge clk_i) disable iff (core_rst || core_rst_q)
    pipe_q[`LAT_STAGES-1][`DAC_W-1] && !msb_prev_q |=> msb_half_q != $past(msb_half_q))
    else $error("halved square did not toggle");

  chk_midscale_reset: assert property (@(posedge clk_i) disable iff (reset_i)
    core_rst_q [*8] |=> dac_code_o == 10'h200)
    else $error("dac not at midscale in reset");

  chk_acc_cleared: assert property (@(posedge clk_i) disable iff (reset_i)
    core_rst_q |-> acc_q == '0)
    else $error("accumulator not cleared");

  chk_start_latency: assert property (@(posedge clk_i) disable iff (reset_i)
    s_release |-> (dac_code_o == 10'h200) [*7])
    else $error("output appeared before latency");

  chk_pin_reset_now: assert property (@(posedge clk_i) disable iff (reset_i)
    reset_pin_i && sel_pin_q |-> dac_code_o == 10'h200)
    else $error("pin reset not immediate");

  chk_tri_select: assert property (@(posedge clk_i) disable iff (core_rst || core_rst_q)
    use_tri |=> pipe_q[0] == $past(tri_code))
    else $error("triangle path not selected");

  chk_sine_select: assert property (@(posedge clk_i) disable iff (core_rst || core_rst_q)
    !ctrl_q.mode_triangle |=> pipe_q[0] == $past(sine_code))
    else $error("sine path not selected");

  chk_reset_source: assert property (@(posedge clk_i) disable iff (reset_i)
    !sel_pin_q && ctrl_q.reset_bit |=> core_rst_q)
    else $error("reset bit ignored");

endmodule : dds_output_select_startup

//--- src/dds_consts.svh
// Purpose: Constants for the synthesizer output-select and start-up block.
// Assumes: 25 MHz master clock; APB register access with 32-bit data.
// Notes:   Offsets are byte addresses; field positions follow the control word.
`ifndef DDS_CONSTS_SVH
`define DDS_CONSTS_SVH

// ==========================================================
// Register offsets
`define OFS_CONTROL     12'h000
`define OFS_FREQ0       12'h004
`define OFS_FREQ1       12'h008
`define OFS_PHASE0      12'h00c
`define OFS_PHASE1      12'h010
`define OFS_STATUS      12'h014

// ==========================================================
// Control field positions
`define BIT_FSEL        11
`define BIT_PSEL        10
`define BIT_PINSW       9
`define BIT_RESET       8
`define BIT_DACPD       6
`define BIT_SQEN        5
`define BIT_CMPSEL      4
`define BIT_HALVE       3
`define BIT_MODE        1

// ==========================================================
// Widths and timing
`define FREQ_W          28
`define PHASE_W         12
`define DAC_W           10
`define LAT_STAGES      7
`define CTRL_W          16
`define STATUS_RST      32'h0000_0001

`endif

//--- src/dds_pkg.sv
// Purpose: Types for the synthesizer output-select and start-up block.
// Assumes: Constants come from dds_consts.svh.
// Notes:   Types only; every number but the run_e state codes lives in the header.
`include "dds_consts.svh"

package dds_pkg;

  // ==========================================================
  // Control word fields
  typedef struct packed {
    logic       square_pin_enable;
    logic       comparator_route_select;
    logic       halve_square_frequency;
    logic       mode_triangle;
    logic       dac_powerdown_bit;
    logic       pin_or_software_select;
    logic       reset_bit;
    logic       freq_sel_bit;
    logic       phase_sel_bit;
  } ctrl_s;

  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_FILL  = 3'b010,
    ST_RUN   = 3'b100
  } run_e;

endpackage : dds_pkg

//--- bench/host_model.sv
// Purpose: Host that programs the synthesizer over APB.
// Assumes: One transfer at a time; the slave may add wait states.
// Notes:   Idle address and data show the inverse of the last value.
`include "dds_consts.svh"

module host_model (
  input  wire logic        clk_i,     // Master clock
  output logic             psel_o,    // APB select
  output logic             penable_o, // APB enable
  output logic             pwrite_o,  // APB direction
  output logic [11:0]      paddr_o,   // APB address
  output logic [31:0]      pwdata_o,  // APB write data
  input  wire logic [31:0] prdata_i,  // APB read data
  input  wire logic        pready_i,  // APB ready
  input  wire logic        pslverr_i  // APB error
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 12'h000;
    pwdata_o  = 32'h0000_0000;
  end

  // ==========================================================
  // Control word
  // DAC on, reserved mix avoided
  function automatic logic [31:0] cw(input logic en, cmp, hv, tw, pin, rb);
    logic [31:0] w;
    w               = 32'h0000_0000;
    w[`BIT_SQEN]    = en;
    w[`BIT_CMPSEL]  = cmp;
    w[`BIT_HALVE]   = hv;
    w[`BIT_MODE]    = tw & ~en;
    w[`BIT_DACPD]   = 1'b0;
    w[`BIT_PINSW]   = pin;
    w[`BIT_RESET]   = rb;
    return w;
  endfunction : cw

  // ==========================================================
  // Transfer
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= wr;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    paddr_o   <= ~a;
    pwdata_o  <= ~d;
  endtask : xfer
endmodule : host_model

//--- bench/dds_output_select_startup_bench.sv
// Purpose: Self-checking bench for output routing and start-up.
// Assumes: Registers read back what was written.
// Notes:   Shapes are judged by slope statistics, not exact codes.
`include "dds_consts.svh"

module dds_output_select_startup_bench import dds_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk_i = 1'b0;
  logic              reset_i = 1'b1;
  logic              reset_pin = 1'b1;
  logic              fsel = 1'b0;
  logic              psel_pin = 1'b0;
  logic              cmp = 1'b0;
  logic              psel, penable, pwrite, pready, pslverr, dac_on, sq, sq_oe, e;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, q;
  logic [`DAC_W-1:0] dac;
  int                n_fail = 0;
  int                samples_checked = 0;
  int                cyc = 0;
  int                n, k;

  typedef struct {logic en, cm, hv, oe; int edges;} row_s;
  // Edges: 0 none counted, -1 comparator follow, else MSB rises in 256 clocks
  row_s rows[4] = '{'{0, 1, 1, 0, 0}, '{1, 1, 1, 1, -1}, '{1, 0, 1, 1, 16}, '{1, 0, 0, 1, 8}};

  host_model host (.clk_i(clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

  dds_output_select_startup dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .reset_pin_i(reset_pin), .freq_register_select_pin_i(fsel),
    .phase_select_pin_i(psel_pin), .comparator_i(cmp), .dac_code_o(dac), .dac_powered_o(dac_on),
    .square_o(sq), .square_oe_o(sq_oe));

  always #20 clk_i = ~clk_i;

  // Hang guard, well above the roughly 1600 clocks the run needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      close_out();
    end
  end

  // ==========================================================
  // Helpers
  task automatic check(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : check

  task automatic close_out;
    $display("compares %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask : rd

  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
  endtask : tick

  task automatic rises(input int c, output int r);
    logic p;
    r = 0;
    p = sq;
    repeat (c) begin
      @(posedge clk_i);
      if (sq === 1'b1 && p === 1'b0) r++;
      p = sq;
    end
  endtask : rises

  // Number of distinct step sizes over 256 samples
  task automatic spread(output int s);
    logic [31:0] m;
    logic [9:0]  pv;
    int          d;
    m  = 32'h0000_0000;
    pv = dac;
    repeat (256) begin
      @(posedge clk_i);
      d = int'(dac) - int'(pv);
      if (d < 0) d = -d;
      if (d > 31) d = 31;
      m[d] = 1'b1;
      pv = dac;
    end
    s = $countones(m);
  endtask : spread

  // ==========================================================
  // Sequence
  initial begin
    tick(2);
    check(dac === 10'h200 && sq_oe === 1'b0 && pready === 1'b0, "reset state");
    reset_i <= 1'b0;
    // load all while held in reset
    wr(`OFS_FREQ0, 32'h0100_0000);
    wr(`OFS_FREQ1, 32'h0010_0000);
    wr(`OFS_PHASE0, 32'h0000_0200);
    wr(`OFS_PHASE1, 32'h0000_0000);
    wr(`OFS_CONTROL, host.cw(0, 0, 0, 1, 1, 0));
    tick(3);
    reset_pin <= 1'b0;
    n = 0;
    while (dac === 10'h200 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check(n == 8 || n == 9, "start-up latency");
    check(dac_on === 1'b1, "dac power");
    tick(1);
    fsel <= 1'b1;
    tick(20);
    spread(k);
    check(k <= 4, "triangle slope");
    wr(`OFS_CONTROL, host.cw(0, 0, 0, 0, 1, 0));
    tick(20);
    spread(k);
    check(k >= 6, "sine shape");
    wr(`OFS_CONTROL, host.cw(1, 0, 1, 0, 1, 0));
    tick(20);
    rises(256, n);
    check(n <= 2, "slow carrier");
    fsel <= 1'b0;
    foreach (rows[i]) begin
      wr(`OFS_CONTROL, host.cw(rows[i].en, rows[i].cm, rows[i].hv, 0, 1, 0));
      cmp <= 1'b1;
      tick(20);
      check(sq_oe === rows[i].oe, "square enable");
      if (rows[i].edges < 0) begin
        check(sq === 1'b1, "comparator high");
        cmp <= 1'b0;
        tick(6);
        check(sq === 1'b0, "comparator low");
      end
      if (rows[i].edges > 0) begin
        rises(256, n);
        check(n >= rows[i].edges - 1 && n <= rows[i].edges + 1, "msb rate");
      end
    end
    wr(`OFS_FREQ0, 32'h0000_0000);
    wr(`OFS_PHASE0, 32'h0000_0400);
    wr(`OFS_PHASE1, 32'h0000_0c00);
    wr(`OFS_CONTROL, host.cw(0, 0, 0, 0, 1, 0));
    reset_pin <= 1'b1;
    tick(2);
    reset_pin <= 1'b0;
    tick(20);
    check(dac > 10'h300, "phase zero");
    psel_pin <= 1'b1;
    tick(20);
    check(dac < 10'h100, "phase one");
    reset_pin <= 1'b1;
    @(negedge clk_i);
    check(dac === 10'h200, "pin reset immediate");
    wr(`OFS_CONTROL, host.cw(0, 0, 0, 0, 0, 0));
    tick(20);
    check(dac > 10'h300, "pin ignored in software mode");
    wr(`OFS_CONTROL, host.cw(0, 0, 0, 0, 0, 1));
    tick(4);
    check(dac === 10'h200, "reset bit");
    reset_pin <= 1'b0;
    reset_i <= 1'b1;
    tick(2);
    reset_i <= 1'b0;
    rd(`OFS_PHASE0);
    check(q[11:0] === 12'h400, "phase kept");
    rd(`OFS_FREQ1);
    check(q[27:0] === 28'h010_0000, "frequency kept");
    rd(12'h018);
    check(e === 1'b1 && q === 32'h0000_0000, "unmapped read");
    close_out();
  end
endmodule : dds_output_select_startup_bench
